// ===== serial_pins_consts.vh
// Constants for the serial controller pin interface
`ifndef SERIAL_PINS_CONSTS_VH
`define SERIAL_PINS_CONSTS_VH

// ----------------------------------------
// Receive clock factor codes
// ----------------------------------------
`define FACTOR_X1 2'h0
`define FACTOR_X16 2'h1
`define FACTOR_X32 2'h2
`define FACTOR_X64 2'h3
`define LAST_X1 6'h00
`define LAST_X16 6'h0F
`define LAST_X32 6'h1F
`define LAST_X64 6'h3F

// ----------------------------------------
// Receive sync modes
// ----------------------------------------
`define SYNC_ASYNC 2'h0
`define SYNC_EXT 2'h1
`define SYNC_INT 2'h2
`define SYNC_FRAME 2'h3

// ----------------------------------------
// Clock pin output sources
// ----------------------------------------
`define CLK_LOOP 2'h0
`define CLK_XTAL 2'h1
`define CLK_BRG 2'h2
`define CLK_TX 2'h3

// ----------------------------------------
// Pin functions and address fields
// ----------------------------------------
`define DTR_FOLLOW 1'b0
`define DTR_DMA 1'b1
`define WREQ_WAIT 1'b0
`define WREQ_REQ 1'b1
`define CHAN_ADDR_BIT 0
`define DSEL_ADDR_BIT 1
`define BYTE_ZERO 8'h00

`endif

// ===== serial_pins.v
// Pin-level logic of the dual-channel serial controller
`timescale 1ns/10ps
`default_nettype none
`include "serial_pins_consts.vh"

module serial_pins #(
	parameter DW = 8
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Host bus pins
	input wire bus_muxed,
	input wire rd_n,
	input wire wr_n,
	input wire ce_n,
	input wire chan_sel,
	input wire data_ctrl,
	input wire addr_strobe_n,
	input wire data_strobe_n,
	input wire chip_select_zero_n,
	input wire chip_select_one,
	input wire read_write,
	input wire [DW-1:0] muxed_addr_data_in,
	output reg [DW-1:0] muxed_addr_data_out,
	output reg muxed_addr_data_oe,
	// Daisy chain pins
	input wire irq_ack_n,
	input wire priority_in,
	output reg priority_out,
	output reg irq_n_out,
	output reg irq_n_oe,
	// Channel pins
	input wire clear_to_send_in_a,
	input wire clear_to_send_in_b,
	input wire carrier_detect_in_a,
	input wire carrier_detect_in_b,
	input wire serial_in_a,
	input wire serial_in_b,
	input wire rx_tx_clock_pin_a,
	input wire rx_tx_clock_pin_b,
	input wire sync_pin_a_in,
	input wire sync_pin_b_in,
	output reg sync_pin_a_out,
	output reg sync_pin_a_oe,
	output reg sync_pin_b_out,
	output reg sync_pin_b_oe,
	output reg serial_out_a,
	output reg serial_out_b,
	output reg request_to_send_out_a,
	output reg request_to_send_out_b,
	output reg terminal_ready_request_a,
	output reg terminal_ready_request_b,
	output reg tx_rx_clock_pin_a_out,
	output reg tx_rx_clock_pin_a_oe,
	output reg tx_rx_clock_pin_b_out,
	output reg tx_rx_clock_pin_b_oe,
	output reg wait_request_a_out,
	output reg wait_request_a_oe,
	output reg wait_request_b_out,
	output reg wait_request_b_oe,
	// Per-channel controls, index 0 is channel a
	input wire [1:0] auto_enable,
	input wire [1:0] ext_irq_enable,
	input wire [1:0] dtr_bit,
	input wire [1:0] dtr_mode,
	input wire [1:0] rts_bit,
	input wire [1:0] tx_empty,
	input wire [1:0] xtal_sel,
	input wire [3:0] sync_mode,
	input wire [3:0] clock_factor,
	input wire [1:0] clk_pin_out_en,
	input wire [3:0] clk_pin_src,
	input wire [1:0] loop_clk,
	input wire [1:0] xtal_clk,
	input wire [1:0] brg_clk,
	input wire [1:0] tx_clk,
	input wire [1:0] tx_data,
	input wire [1:0] pattern_hit,
	input wire [1:0] flag_hit,
	input wire [1:0] wreq_mode,
	input wire [1:0] dma_req,
	// Per-channel status
	output reg [1:0] tx_enable,
	output reg [1:0] rx_enable,
	output reg [1:0] cts_level,
	output reg [1:0] dcd_level,
	output reg [1:0] ext_event,
	output reg [1:0] rx_data,
	output reg [1:0] rx_sample,
	output reg [1:0] sync_hunt,
	output reg [1:0] assembly_start,
	// Interrupt user side
	input wire irq_pending,
	input wire ius_clear,
	input wire [DW-1:0] vector,
	output reg ius,
	// Register access user side
	output reg dev_reset,
	output reg rd_req,
	output reg rd_chan,
	output reg rd_data_sel,
	output reg [DW-1:0] rd_addr,
	input wire [DW-1:0] rd_data,
	output reg wr_valid,
	input wire wr_ready,
	output reg wr_chan,
	output reg wr_data_sel,
	output reg [DW-1:0] wr_addr,
	output reg [DW-1:0] wr_data
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
localparam NP = 2 * DW + 25;
localparam BW = 2 * DW + 2;
localparam S_IDLE = 4'h1;
localparam S_READ = 4'h2;
localparam S_WRITE = 4'h4;
localparam S_ACK = 4'h8;

wire [NP-1:0] pins_raw = {rd_n, wr_n, ce_n, chan_sel, data_ctrl, addr_strobe_n,
	data_strobe_n, chip_select_zero_n, chip_select_one, read_write, irq_ack_n,
	priority_in, muxed_addr_data_in, rd_data, clear_to_send_in_b, clear_to_send_in_a,
	carrier_detect_in_b, carrier_detect_in_a, serial_in_b, serial_in_a,
	rx_tx_clock_pin_b, rx_tx_clock_pin_a, sync_pin_b_in, sync_pin_a_in,
	2'h0, 1'b0};
reg [NP-1:0] f1_q, f2_q, f3_q, st_q, pv_q;
wire s_rd_n, s_wr_n, s_ce_n, s_chan, s_dc, s_as_n, s_ds_n, s_cs0_n, s_cs1, s_rw;
wire s_ack_n, s_pri, unused_a, unused_b, unused_c;
wire [DW-1:0] s_ad, s_rdd;
wire [1:0] s_cts, s_dcd, s_rxd, s_rxc, s_syn;
assign {s_rd_n, s_wr_n, s_ce_n, s_chan, s_dc, s_as_n, s_ds_n, s_cs0_n, s_cs1, s_rw,
	s_ack_n, s_pri, s_ad, s_rdd, s_cts, s_dcd, s_rxd, s_rxc, s_syn,
	unused_a, unused_b, unused_c} = st_q;
wire [1:0] p_cts = pv_q[12:11];
wire [1:0] p_dcd = pv_q[10:9];
wire [1:0] p_rxc = pv_q[6:5];
wire [1:0] p_syn = pv_q[4:3];
wire p_as_n = pv_q[NP-6];

// Change accepted only once stages two and three agree
always @(posedge clk) begin
	f1_q <= pins_raw;
	f2_q <= f1_q;
	f3_q <= f2_q;
	st_q <= (f2_q & f3_q) | (st_q & (f2_q ^ f3_q));
	pv_q <= st_q;
end

// ----------------------------------------
// Bus decode
// ----------------------------------------
function [5:0] factor_last;
	input [1:0] code;
	begin
		case (code)
			`FACTOR_X1: factor_last = `LAST_X1;
			`FACTOR_X16: factor_last = `LAST_X16;
			`FACTOR_X32: factor_last = `LAST_X32;
			default: factor_last = `LAST_X64;
		endcase
	end
endfunction

reg [3:0] st_bus_q;
reg [DW-1:0] addr_q;
reg cs0_q, pend_q, vec_q;
reg [BW-1:0] acc_q, spare_q;
reg spare_valid_q;
wire coincide = bus_muxed ? (~s_as_n & ~s_ds_n) : (~s_rd_n & ~s_wr_n);
wire sel = bus_muxed ? (~cs0_q & s_cs1) : ~s_ce_n;
wire rd_act = ~coincide & (bus_muxed ? (~s_ds_n & s_rw) : ~s_rd_n);
wire wr_act = ~coincide & (bus_muxed ? (~s_ds_n & ~s_rw) : ~s_wr_n);
wire acc_chan = bus_muxed ? addr_q[`CHAN_ADDR_BIT] : s_chan;
wire acc_dsel = bus_muxed ? addr_q[`DSEL_ADDR_BIT] : s_dc;
wire ack = ~s_ack_n;
wire requesting = irq_pending & s_pri & ~ius;
wire pop = wr_valid & wr_ready;
wire push = pend_q & ~spare_valid_q;
wire [1:0] wait_need;
assign wait_need[0] = (pend_q | st_bus_q == S_WRITE) & spare_valid_q & ~acc_q[BW-1];
assign wait_need[1] = (pend_q | st_bus_q == S_WRITE) & spare_valid_q & acc_q[BW-1];

always @(posedge clk) begin
	dev_reset <= coincide;
	rd_req <= 1'b0;
	if (rst | coincide) begin
		st_bus_q <= S_IDLE;
		addr_q <= `BYTE_ZERO;
		cs0_q <= 1'b1;
		pend_q <= 1'b0;
		vec_q <= 1'b0;
		acc_q <= {BW{1'b0}};
		ius <= 1'b0;
		muxed_addr_data_out <= `BYTE_ZERO;
		muxed_addr_data_oe <= 1'b0;
		rd_chan <= 1'b0;
		rd_data_sel <= 1'b0;
		rd_addr <= `BYTE_ZERO;
		priority_out <= 1'b0;
		irq_n_out <= 1'b0;
		irq_n_oe <= 1'b0;
	end else begin
		if (bus_muxed & s_as_n & ~p_as_n) begin
			addr_q <= s_ad;
			cs0_q <= s_cs0_n;
		end
		if (push)
			pend_q <= 1'b0;
		if (ius_clear)
			ius <= 1'b0;
		priority_out <= s_pri & ~ius & ~(ack & irq_pending);
		irq_n_oe <= requesting;
		case (st_bus_q)
			S_IDLE: begin
				if (ack & rd_act) begin
					st_bus_q <= S_ACK;
					if (requesting) begin
						vec_q <= 1'b1;
						ius <= 1'b1;
					end
				end else if (rd_act & sel) begin
					st_bus_q <= S_READ;
					rd_req <= 1'b1;
					rd_chan <= acc_chan;
					rd_data_sel <= acc_dsel;
					rd_addr <= addr_q;
				end else if (wr_act & sel & ~pend_q & ~ack) begin
					st_bus_q <= S_WRITE;
					acc_q <= {acc_chan, acc_dsel, addr_q, s_ad};
				end
			end
			S_READ: begin
				muxed_addr_data_out <= s_rdd;
				muxed_addr_data_oe <= rd_act;
				if (!rd_act)
					st_bus_q <= S_IDLE;
			end
			S_WRITE: begin
				acc_q[DW-1:0] <= s_ad;
				if (bus_muxed & ~s_cs1)
					st_bus_q <= S_IDLE;
				else if (!wr_act) begin
					pend_q <= 1'b1;
					st_bus_q <= S_IDLE;
				end
			end
			S_ACK: begin
				muxed_addr_data_out <= vector;
				muxed_addr_data_oe <= vec_q & rd_act;
				if (!rd_act) begin
					vec_q <= 1'b0;
					st_bus_q <= S_IDLE;
				end
			end
			default: st_bus_q <= S_IDLE;
		endcase
	end
end

// ----------------------------------------
// Two-entry write buffer
// ----------------------------------------
// Second entry absorbs a write while the user side stalls
always @(posedge clk) begin
	if (rst) begin
		wr_valid <= 1'b0;
		spare_valid_q <= 1'b0;
		spare_q <= {BW{1'b0}};
		{wr_chan, wr_data_sel, wr_addr, wr_data} <= {BW{1'b0}};
	end else if (push) begin
		if (!wr_valid || pop) begin
			{wr_chan, wr_data_sel, wr_addr, wr_data} <= acc_q;
			wr_valid <= 1'b1;
		end else begin
			spare_q <= acc_q;
			spare_valid_q <= 1'b1;
		end
	end else if (pop) begin
		if (spare_valid_q) begin
			{wr_chan, wr_data_sel, wr_addr, wr_data} <= spare_q;
			spare_valid_q <= 1'b0;
		end else
			wr_valid <= 1'b0;
	end
end

// ----------------------------------------
// Channel pins
// ----------------------------------------
reg [5:0] rxcnt_q [0:1];
reg [1:0] rts_q, sync_oe_d, clk_d, wreq_out_d, wreq_oe_d;
integer c;
always @(posedge clk) begin
	for (c = 0; c < 2; c = c + 1) begin
		if (rst) begin
			rxcnt_q[c] <= 6'h00;
			rts_q[c] <= 1'b1;
			tx_enable[c] <= 1'b0;
			rx_enable[c] <= 1'b0;
			ext_event[c] <= 1'b0;
			rx_sample[c] <= 1'b0;
			sync_hunt[c] <= 1'b0;
			assembly_start[c] <= 1'b0;
			sync_oe_d[c] <= 1'b0;
			clk_d[c] <= 1'b0;
			wreq_out_d[c] <= 1'b1;
			wreq_oe_d[c] <= 1'b0;
		end else begin
			tx_enable[c] <= ~auto_enable[c] | ~s_cts[c];
			rx_enable[c] <= ~auto_enable[c] | ~s_dcd[c];
			ext_event[c] <= ext_irq_enable[c] &
				((s_cts[c] ^ p_cts[c]) | (s_dcd[c] ^ p_dcd[c]));
			rx_sample[c] <= 1'b0;
			if (s_rxc[c] & ~p_rxc[c]) begin
				if (rxcnt_q[c] >= factor_last(clock_factor[2*c +: 2])) begin
					rxcnt_q[c] <= 6'h00;
					rx_sample[c] <= 1'b1;
				end else
					rxcnt_q[c] <= rxcnt_q[c] + 6'h01;
			end
			if (rts_bit[c])
				rts_q[c] <= 1'b0;
			else if (sync_mode[2*c +: 2] != `SYNC_ASYNC || !auto_enable[c] || tx_empty[c])
				rts_q[c] <= 1'b1;
			if (sync_mode[2*c +: 2] == `SYNC_ASYNC && !xtal_sel[c])
				sync_hunt[c] <= ~s_syn[c];
			// Pulse marks the cycle that sync is seen going low in external sync mode
			assembly_start[c] <= sync_mode[2*c +: 2] == `SYNC_EXT && !xtal_sel[c] &&
				~s_syn[c] & p_syn[c];
			sync_oe_d[c] <= ~xtal_sel[c] &
				((sync_mode[2*c +: 2] == `SYNC_INT & pattern_hit[c]) |
				(sync_mode[2*c +: 2] == `SYNC_FRAME & flag_hit[c]));
			case (clk_pin_src[2*c +: 2])
				`CLK_LOOP: clk_d[c] <= loop_clk[c];
				`CLK_XTAL: clk_d[c] <= xtal_clk[c];
				`CLK_BRG: clk_d[c] <= brg_clk[c];
				default: clk_d[c] <= tx_clk[c];
			endcase
			if (wreq_mode[c] == `WREQ_REQ) begin
				wreq_out_d[c] <= ~dma_req[c];
				wreq_oe_d[c] <= 1'b1;
			end else begin
				wreq_out_d[c] <= 1'b0;
				wreq_oe_d[c] <= wait_need[c];
			end
		end
	end
end

// Pin outputs registered from the channel state
always @(posedge clk) begin
	if (rst) begin
		cts_level <= 2'h0;
		dcd_level <= 2'h0;
		rx_data <= 2'h0;
	end else begin
		cts_level <= s_cts;
		dcd_level <= s_dcd;
		rx_data <= s_rxd;
	end
	request_to_send_out_a <= rst | rts_q[0];
	request_to_send_out_b <= rst | rts_q[1];
	terminal_ready_request_a <= rst | ((dtr_mode[0] == `DTR_DMA) ? ~dma_req[0] : ~dtr_bit[0]);
	terminal_ready_request_b <= rst | ((dtr_mode[1] == `DTR_DMA) ? ~dma_req[1] : ~dtr_bit[1]);
	serial_out_a <= rst | tx_data[0];
	serial_out_b <= rst | tx_data[1];
	sync_pin_a_out <= 1'b0;
	sync_pin_b_out <= 1'b0;
	sync_pin_a_oe <= ~rst & sync_oe_d[0];
	sync_pin_b_oe <= ~rst & sync_oe_d[1];
	tx_rx_clock_pin_a_out <= ~rst & clk_d[0];
	tx_rx_clock_pin_b_out <= ~rst & clk_d[1];
	tx_rx_clock_pin_a_oe <= ~rst & clk_pin_out_en[0];
	tx_rx_clock_pin_b_oe <= ~rst & clk_pin_out_en[1];
	wait_request_a_out <= rst | wreq_out_d[0];
	wait_request_b_out <= rst | wreq_out_d[1];
	wait_request_a_oe <= ~rst & wreq_oe_d[0];
	wait_request_b_oe <= ~rst & wreq_oe_d[1];
end

endmodule
`default_nettype wire

// ===== serial_pins_asserts.sv
// Port-level assertions for the serial pins block
`timescale 1ns/10ps
`default_nettype none
module serial_pins_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host side
	input wire logic bus_muxed,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic rd_req,
	input wire logic muxed_addr_data_oe,
	input wire logic dev_reset,
	// Daisy chain
	input wire logic priority_in,
	input wire logic priority_out,
	input wire logic ius,
	// Channels
	input wire logic [1:0] auto_enable,
	input wire logic clear_to_send_in_a,
	input wire logic carrier_detect_in_b,
	input wire logic [1:0] tx_enable,
	input wire logic [1:0] rx_enable,
	input wire logic [1:0] dtr_mode,
	input wire logic [1:0] dtr_bit,
	input wire logic terminal_ready_request_a,
	input wire logic [1:0] rts_bit,
	input wire logic request_to_send_out_a
);
	// ------
	// Assertions
	// ------
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence both_strobes;
		!bus_muxed && !rd_n && !wr_n;
	endsequence
	a_tx_auto_enable: assert property (
		(auto_enable[0] && $stable(clear_to_send_in_a)) [*8] |-> tx_enable[0] == !clear_to_send_in_a)
		else $error("transmitter enable wrong under auto enable");
	a_rx_auto_enable: assert property (
		(auto_enable[1] && $stable(carrier_detect_in_b)) [*8] |-> rx_enable[1] == !carrier_detect_in_b)
		else $error("receiver enable wrong under auto enable");
	a_dtr_follows_bit: assert property (
		(!dtr_mode[0] && $stable(dtr_bit[0])) [*4] |-> terminal_ready_request_a == !dtr_bit[0])
		else $error("terminal ready pin does not follow its bit");
	a_rts_asserts: assert property (rts_bit[0] [*5] |-> !request_to_send_out_a)
		else $error("request to send not low while bit set");
	a_prio_needs_in: assert property (!priority_in [*6] |-> !priority_out)
		else $error("priority out high without priority in");
	a_prio_under_service: assert property (ius |=> !priority_out)
		else $error("priority out high while under service");
	a_read_drives_bus: assert property (rd_req |=> muxed_addr_data_oe)
		else $error("bus not driven after read request");
	a_strobe_reset: assert property (both_strobes [*6] |-> dev_reset)
		else $error("no reset on coincident read and write");
endmodule
`default_nettype wire

// ===== host_model.sv
// Host processor and upstream chain model for the serial pins block
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input wire logic clk,
	// Strobe bus
	output var logic rd_n,
	output var logic wr_n,
	output var logic ce_n,
	output var logic chan_sel,
	output var logic data_ctrl,
	output var logic [7:0] muxed_addr_data_in,
	// Daisy chain
	output var logic priority_in
);
	initial begin
		{rd_n, wr_n, ce_n, chan_sel, data_ctrl, priority_in} = 6'h39;
		muxed_addr_data_in = 8'hA5;
	end
	task automatic access(input logic rd, input logic [1:0] sel, input logic [7:0] d);
		@(negedge clk);
		{chan_sel, data_ctrl} = sel;
		muxed_addr_data_in = rd ? ~muxed_addr_data_in : d;
		{rd_n, wr_n, ce_n} = {~rd, rd, 1'b0};
		hold();
	endtask
	task automatic coincide();
		@(negedge clk);
		{rd_n, wr_n} = 2'h0;
		hold();
	endtask
	// Data kept past release: the write is taken after synchronising
	task automatic hold();
		repeat (8) @(negedge clk);
		{rd_n, wr_n, ce_n} = 3'h7;
		repeat (4) @(negedge clk);
		muxed_addr_data_in = ~muxed_addr_data_in;
		repeat (4) @(negedge clk);
	endtask
	// Address or data phase value for the multiplexed bus
	task automatic put(input logic [7:0] d);
		muxed_addr_data_in = d;
	endtask
	task automatic upstream(input logic busy);
		@(negedge clk);
		priority_in = ~busy;
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the serial pins block
`timescale 1ns/10ps
`default_nettype none
`include "serial_pins_consts.vh"
module tb;
	logic clk, rst, bus_muxed, rd_n, wr_n, ce_n, chan_sel, data_ctrl, addr_strobe_n;
	logic data_strobe_n, chip_select_zero_n, chip_select_one, read_write, irq_ack_n;
	logic priority_in, clear_to_send_in_a, clear_to_send_in_b, carrier_detect_in_a;
	logic carrier_detect_in_b, serial_in_a, serial_in_b, rx_tx_clock_pin_a, rx_tx_clock_pin_b;
	logic sync_pin_a_in, sync_pin_b_in, sync_a_ext, sync_b_ext, irq_pending, ius_clear, wr_ready;
	logic [7:0] muxed_addr_data_in, vector, rd_data, muxed_addr_data_out, rd_addr, wr_addr, wr_data;
	logic [1:0] auto_enable, ext_irq_enable, dtr_bit, dtr_mode, rts_bit, tx_empty, xtal_sel;
	logic [1:0] clk_pin_out_en, loop_clk, xtal_clk, brg_clk, tx_clk, tx_data, pattern_hit;
	logic [1:0] flag_hit, wreq_mode, dma_req, tx_enable, rx_enable, cts_level, dcd_level;
	logic [1:0] ext_event, rx_data, rx_sample, sync_hunt, assembly_start, rd_seen;
	logic [3:0] sync_mode, clock_factor, clk_pin_src;
	logic priority_out, irq_n_out, irq_n_oe, muxed_addr_data_oe, sync_pin_a_out, sync_pin_a_oe;
	logic sync_pin_b_out, sync_pin_b_oe, serial_out_a, serial_out_b, request_to_send_out_a;
	logic request_to_send_out_b, terminal_ready_request_a, terminal_ready_request_b;
	logic tx_rx_clock_pin_a_out, tx_rx_clock_pin_a_oe, tx_rx_clock_pin_b_out;
	logic tx_rx_clock_pin_b_oe, wait_request_a_out, wait_request_a_oe, wait_request_b_out;
	logic wait_request_b_oe, ius, dev_reset, rd_req, rd_chan, rd_data_sel, wr_valid, wr_chan;
	logic wr_data_sel, dev_seen, wait_seen, asm_seen;
	logic [7:0] bus_seen, smp_cnt;
	logic [63:0] r;
	logic [9:0] exp_q[$];
	integer seed, errors, cmp_count;
	serial_pins serial_pins_i (.*);
	host_model host_model_i (.*);
	// Sync pins are two-way: the device wins while it drives
	assign sync_pin_a_in = sync_pin_a_oe ? sync_pin_a_out : sync_a_ext;
	assign sync_pin_b_in = sync_pin_b_oe ? sync_pin_b_out : sync_b_ext;
	always #2.5 clk = ~clk;
	// ------
	// Helpers
	// ------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic rts_known(input logic on, input logic [1:0] mode, input logic au,
		input logic empty);
		return on || mode != `SYNC_ASYNC || !au || empty;
	endfunction
	task automatic set_chan();
		{auto_enable, ext_irq_enable, dtr_bit, dtr_mode, rts_bit, tx_empty, xtal_sel,
			clk_pin_out_en, loop_clk, xtal_clk, brg_clk, tx_clk, tx_data, pattern_hit,
			flag_hit, dma_req, wreq_mode, sync_mode, clock_factor, clk_pin_src} = r[45:0];
		{clear_to_send_in_a, clear_to_send_in_b, carrier_detect_in_a, carrier_detect_in_b,
			serial_in_a, serial_in_b, rx_tx_clock_pin_a, rx_tx_clock_pin_b, sync_a_ext,
			sync_b_ext} = r[55:46];
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		if (muxed_addr_data_oe)
			bus_seen <= muxed_addr_data_out;
		if (rd_req)
			rd_seen <= {rd_chan, rd_data_sel};
		if (dev_reset)
			dev_seen <= 1'b1;
		if (wait_request_a_oe)
			wait_seen <= 1'b1;
		if (assembly_start[0])
			asm_seen <= 1'b1;
		if (rx_sample[0])
			smp_cnt <= smp_cnt + 8'h01;
		if (wr_valid && wr_ready)
			check("write", {6'h0, exp_q.pop_front()}, {6'h0, wr_chan, wr_data_sel, wr_data});
	end
	initial begin
		repeat (6000) @(posedge clk);
		errors = errors + 1;
		print_verdict();
	end
	// ------
	// Tests
	// ------
	initial begin
		{clk, rst, bus_muxed, read_write, chip_select_one, irq_pending, ius_clear} = 7'h20;
		{addr_strobe_n, data_strobe_n, chip_select_zero_n, irq_ack_n, wr_ready} = 5'h1E;
		{vector, rd_data, bus_seen, rd_seen, dev_seen, wait_seen, asm_seen, smp_cnt} = 37'h0;
		{seed, errors, cmp_count} = {32'd15357, 64'd0};
		r = 64'h0;
		set_chan();
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check("wait oe", 16'h0, {14'h0, wait_request_a_oe, wait_request_b_oe});
		check("rts idle", 16'h3, {14'h0, request_to_send_out_a, request_to_send_out_b});
		// Third write finds both entries full while the receiver stalls
		for (int i = 0; i < 3; i++) begin
			r = {$random(seed), $random(seed)};
			exp_q.push_back(r[9:0] & {i != 2, 9'h1FF});
			host_model_i.access(1'b0, r[9:8] & {i != 2, 1'b1}, r[7:0]);
		end
		check("wait full", 16'h1, {15'h0, wait_seen});
		repeat (40) begin
			@(negedge clk);
			r = {$random(seed), $random(seed)};
			wr_ready = r[0];
		end
		check("drained", 16'h0, exp_q.size() & 16'hFFFF);
		$display("write test done");
		// Multiplexed write: address 3 means channel b, data transfer
		wr_ready = 1'b1;
		{bus_muxed, chip_select_one, read_write, chip_select_zero_n} = 4'hC;
		host_model_i.put(8'h03);
		addr_strobe_n = 1'b0;
		repeat (6) @(negedge clk);
		addr_strobe_n = 1'b1;
		repeat (6) @(negedge clk);
		exp_q.push_back({2'h3, r[39:32]});
		host_model_i.put(r[39:32]);
		data_strobe_n = 1'b0;
		repeat (8) @(negedge clk);
		data_strobe_n = 1'b1;
		repeat (8) @(negedge clk);
		{bus_muxed, chip_select_one, chip_select_zero_n} = 3'h1;
		check("muxed addr", 16'h0003, {8'h0, wr_addr});
		check("muxed drained", 16'h0, exp_q.size() & 16'hFFFF);
		$display("muxed write test done");
		rd_data = r[15:8];
		bus_seen = ~r[15:8];
		host_model_i.access(1'b1, 2'h2, 8'h00);
		check("read sel", 16'h2, {14'h0, rd_seen});
		check("read data", {8'h0, rd_data}, {8'h0, bus_seen});
		$display("read test done");
		host_model_i.coincide();
		check("strobe reset", 16'h1, {15'h0, dev_seen});
		dev_seen = 1'b0;
		{bus_muxed, addr_strobe_n, data_strobe_n} = 3'h4;
		repeat (8) @(negedge clk);
		{addr_strobe_n, data_strobe_n} = 2'h3;
		repeat (8) @(negedge clk);
		bus_muxed = 1'b0;
		check("muxed reset", 16'h1, {15'h0, dev_seen});
		$display("reset test done");
		{vector, bus_seen} = {r[23:16], ~r[23:16]};
		{irq_pending, irq_ack_n} = 2'h2;
		repeat (6) @(negedge clk);
		check("irq pin", 16'h1, {15'h0, irq_n_oe});
		host_model_i.access(1'b1, 2'h0, 8'h00);
		check("vector", {8'h0, vector}, {8'h0, bus_seen});
		check("ack out", 16'h2, {14'h0, ius, priority_out});
		{irq_pending, irq_ack_n, ius_clear} = 3'h3;
		@(negedge clk);
		ius_clear = 1'b0;
		repeat (8) @(negedge clk);
		check("chain free", 16'h1, {14'h0, ius, priority_out});
		host_model_i.upstream(1'b1);
		repeat (8) @(negedge clk);
		check("chain blocked", 16'h0, {15'h0, priority_out});
		host_model_i.upstream(1'b0);
		$display("daisy chain test done");
		// External sync on channel a, receive clock at factor one
		{sync_mode, xtal_sel, clock_factor, sync_a_ext} = {4'h1, 2'h0, 4'h0, 1'b1};
		repeat (6) @(negedge clk);
		{asm_seen, smp_cnt} = 9'h0;
		repeat (4) begin
			rx_tx_clock_pin_a = ~rx_tx_clock_pin_a;
			repeat (4) @(negedge clk);
		end
		sync_a_ext = 1'b0;
		repeat (4) begin
			rx_tx_clock_pin_a = ~rx_tx_clock_pin_a;
			repeat (4) @(negedge clk);
		end
		sync_a_ext = 1'b1;
		repeat (6) @(negedge clk);
		check("assembly", 16'h1, {15'h0, asm_seen});
		check("rx samples", 16'h4, {8'h0, smp_cnt});
		$display("sync test done");
		for (int k = 0; k < 24; k++) begin
			r = {$random(seed), $random(seed)};
			set_chan();
			repeat (10) @(negedge clk);
			if (auto_enable[0])
				check("tx en", {15'h0, ~clear_to_send_in_a}, {15'h0, tx_enable[0]});
			if (auto_enable[1])
				check("rx en", {15'h0, ~carrier_detect_in_b}, {15'h0, rx_enable[1]});
			if (dtr_mode[0] == `DTR_FOLLOW)
				check("dtr a", {15'h0, ~dtr_bit[0]}, {15'h0, terminal_ready_request_a});
			else
				check("dtr req a", {15'h0, ~dma_req[0]}, {15'h0, terminal_ready_request_a});
			if (rts_known(rts_bit[0], sync_mode[1:0], auto_enable[0], tx_empty[0]))
				check("rts a", {15'h0, ~rts_bit[0]}, {15'h0, request_to_send_out_a});
		end
		$display("channel test done");
		print_verdict();
	end
endmodule
bind serial_pins serial_pins_asserts serial_pins_asserts_i (.*);
`default_nettype wire
